// File: logic/gp_irq_detect.sv
// Per-pin edge and level interrupt detection for one port
`timescale 1ns/1ps
module gp_irq_detect
    import gp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] sense,
    input wire logic [7:0] both,
    input wire logic [7:0] polarity,
    input wire logic [7:0] clr,
    output logic [7:0] raw
);
    typedef struct packed {
        logic primed;
        logic [7:0] prev;
        logic [7:0] latch;
    } gp_det_t;

    gp_det_t s_q;
    gp_det_t s_d;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] hit;

    always_comb begin
        s_d = s_q;
        // No edge is seen on the first cycle after reset
        rise = pin_in & ~s_q.prev & {8{s_q.primed}};
        fall = ~pin_in & s_q.prev & {8{s_q.primed}};
        hit = (both & (rise | fall))
            | (~both & polarity & rise)
            | (~both & ~polarity & fall);
        // A new edge in the clear cycle wins over the clear
        s_d.latch = (s_q.latch & ~clr) | (hit & ~sense);
        s_d.prev = pin_in;
        s_d.primed = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Level pins follow the pin, unlatched; the source must hold it
    assign raw = (sense & ~(pin_in ^ polarity))
        | (~sense & s_q.latch);

    latch_hold_a: assert property (@(posedge clk) disable iff (rst)
        1 |=> (($past(s_q.latch) & ~$past(clr) & ~s_q.latch) == 8'h00))
        else $error("edge latch dropped without a clear");

    rise_set_a: assert property (@(posedge clk) disable iff (rst)
        (!sense[GP_ADC_PIN] && !both[GP_ADC_PIN] && polarity[GP_ADC_PIN]
        && rise[GP_ADC_PIN]) |=> s_q.latch[GP_ADC_PIN])
        else $error("rising edge did not latch");
endmodule

// File: logic/gp_port.sv
// One GPIO port: registers, masked data access, pads, interrupts
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module gp_port
    import gp_pkg::*;
#(
    parameter gp_port_t PORT_ID = GP_PORT_A,
    parameter logic [7:0] PIN_PRESENT = 8'hff
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output gp_pad_t pad_cfg,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    output logic [7:0] alt_in,
    output logic irq,
    output logic adc_trigger
);
    typedef struct packed {
        gp_bus_t bus;
        logic [7:0] rdata;
        logic [7:0] dir;
        logic [7:0] data;
        logic [7:0] sense;
        logic [7:0] both;
        logic [7:0] polarity;
        logic [7:0] mask;
        logic [7:0] afsel;
        gp_pad_t pad;
        logic [7:0] alt_in;
        logic irq;
        logic mis_adc;
        logic adc_trig;
    } gp_state_t;

    localparam gp_state_t ST_RST = '{
        bus: GP_BUS_IDLE, rdata: GP_RST_ZERO, dir: GP_RST_ZERO,
        data: GP_RST_ZERO, sense: GP_RST_ZERO, both: GP_RST_ZERO,
        polarity: GP_RST_ZERO, mask: GP_RST_ZERO,
        afsel: gp_afsel_reset(PORT_ID),
        pad: GP_PAD_RST, alt_in: GP_RST_ZERO,
        irq: 1'b0, mis_adc: 1'b0, adc_trig: 1'b0
    };

    gp_state_t s_q;
    gp_state_t s_d;
    logic [7:0] raw;
    logic [7:0] mis;
    logic [7:0] clr;
    logic [7:0] rd;
    logic [7:0] wv;
    logic [7:0] in_sel;
    logic [7:0] out_v;
    logic [7:0] drv_en;
    logic req;
    logic wr_go;
    logic data_span;
    logic mis_any;

    gp_irq_detect u_detect (
        .clk(clk),
        .rst(rst),
        .pin_in(pad_in & s_q.pad.dig_en),
        .sense(s_q.sense),
        .both(s_q.both),
        .polarity(s_q.polarity),
        .clr(clr),
        .raw(raw)
    );

    assign req = avs_read | avs_write;
    assign data_span = avs_address[11:10] == GP_DATA_SPAN;
    assign wr_go = (s_q.bus == GP_BUS_ANS) & avs_write & avs_byteenable[0];
    // Absent pads are cut from every write
    assign wv = avs_writedata[7:0] & PIN_PRESENT;
    assign in_sel = ~s_q.dir & s_q.pad.dig_en & PIN_PRESENT;
    assign mis = raw & s_q.mask;
    assign mis_any = |mis;

    always_comb begin
        s_d = s_q;
        clr = 8'h00;
        rd = 8'h00;
        s_d.adc_trig = 1'b0;
        s_d.alt_in = pad_in & s_q.pad.dig_en;
        // Input pins capture the pad on every cycle without a data-span write
        s_d.data = (s_q.data & ~in_sel) | (pad_in & in_sel);
        if (data_span) begin
            rd = s_q.data & avs_address[9:GP_MASK_LSB];
        end else begin
            case (avs_address)
                GP_OFF_DIR: rd = s_q.dir;
                GP_OFF_SENSE: rd = s_q.sense;
                GP_OFF_BOTH: rd = s_q.both;
                GP_OFF_POL: rd = s_q.polarity;
                GP_OFF_MASK: rd = s_q.mask;
                GP_OFF_RAW: rd = raw;
                GP_OFF_MIS: rd = mis;
                GP_OFF_AFSEL: rd = s_q.afsel;
                GP_OFF_DRV2: rd = s_q.pad.drv2;
                GP_OFF_DRV4: rd = s_q.pad.drv4;
                GP_OFF_DRV8: rd = s_q.pad.drv8;
                GP_OFF_ODR: rd = s_q.pad.open_drain;
                GP_OFF_PUP: rd = s_q.pad.pull_up;
                GP_OFF_PDN: rd = s_q.pad.pull_down;
                GP_OFF_SLEW: rd = s_q.pad.slew;
                GP_OFF_DEN: rd = s_q.pad.dig_en;
                default: rd = gp_id_byte(avs_address);
            endcase
            rd = rd & PIN_PRESENT;
        end
        // Two-cycle answer keeps read data on a flip-flop
        unique case (s_q.bus)
            GP_BUS_IDLE: begin
                if (req) begin
                    s_d.bus = GP_BUS_ANS;
                    s_d.rdata = rd;
                end
            end
            GP_BUS_ANS: begin
                s_d.bus = GP_BUS_IDLE;
            end
        endcase
        if (wr_go && data_span) begin
            s_d.data = gp_merge(s_q.data, wv,
                avs_address[9:GP_MASK_LSB] & PIN_PRESENT);
        end else if (wr_go) begin
            case (avs_address)
                GP_OFF_DIR: s_d.dir = gp_merge(s_q.dir, wv, PIN_PRESENT);
                GP_OFF_SENSE: begin
                    s_d.sense = gp_merge(s_q.sense, wv, PIN_PRESENT);
                end
                GP_OFF_BOTH: begin
                    s_d.both = gp_merge(s_q.both, wv, PIN_PRESENT);
                end
                GP_OFF_POL: begin
                    s_d.polarity = gp_merge(s_q.polarity, wv, PIN_PRESENT);
                end
                GP_OFF_MASK: begin
                    s_d.mask = gp_merge(s_q.mask, wv, PIN_PRESENT);
                end
                GP_OFF_CLR: clr = wv;
                GP_OFF_AFSEL: begin
                    s_d.afsel = gp_merge(s_q.afsel, wv, PIN_PRESENT);
                end
                // Drive strengths exclude each other; the last write wins
                GP_OFF_DRV2: begin
                    s_d.pad.drv2 = gp_merge(s_q.pad.drv2, wv, PIN_PRESENT);
                    s_d.pad.drv4 = s_q.pad.drv4 & ~wv;
                    s_d.pad.drv8 = s_q.pad.drv8 & ~wv;
                end
                GP_OFF_DRV4: begin
                    s_d.pad.drv4 = gp_merge(s_q.pad.drv4, wv, PIN_PRESENT);
                    s_d.pad.drv2 = s_q.pad.drv2 & ~wv;
                    s_d.pad.drv8 = s_q.pad.drv8 & ~wv;
                end
                GP_OFF_DRV8: begin
                    s_d.pad.drv8 = gp_merge(s_q.pad.drv8, wv, PIN_PRESENT);
                    s_d.pad.drv2 = s_q.pad.drv2 & ~wv;
                    s_d.pad.drv4 = s_q.pad.drv4 & ~wv;
                end
                GP_OFF_ODR: begin
                    s_d.pad.open_drain =
                        gp_merge(s_q.pad.open_drain, wv, PIN_PRESENT);
                end
                GP_OFF_PUP: begin
                    s_d.pad.pull_up =
                        gp_merge(s_q.pad.pull_up, wv, PIN_PRESENT);
                    s_d.pad.pull_down = s_q.pad.pull_down & ~wv;
                end
                GP_OFF_PDN: begin
                    s_d.pad.pull_down =
                        gp_merge(s_q.pad.pull_down, wv, PIN_PRESENT);
                    s_d.pad.pull_up = s_q.pad.pull_up & ~wv;
                end
                GP_OFF_SLEW: begin
                    s_d.pad.slew = gp_merge(s_q.pad.slew, wv, PIN_PRESENT);
                end
                GP_OFF_DEN: begin
                    s_d.pad.dig_en =
                        gp_merge(s_q.pad.dig_en, wv, PIN_PRESENT);
                end
                default: s_d.bus = GP_BUS_IDLE;
            endcase
        end
        s_d.irq = mis_any;
        s_d.mis_adc = mis[GP_ADC_PIN];
        // One pulse per new unmasked event on the converter pin
        s_d.adc_trig = (PORT_ID == GP_PORT_B) && mis[GP_ADC_PIN]
            && !s_q.mis_adc;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Open drain never drives high; it releases instead
    assign out_v = (s_q.afsel & alt_out) | (~s_q.afsel & s_q.data);
    assign drv_en = (s_q.afsel & alt_oe) | (~s_q.afsel & s_q.dir);
    assign pad_out = out_v & ~s_q.pad.open_drain;
    assign pad_oe = drv_en & ~(s_q.pad.open_drain & out_v)
        & PIN_PRESENT;
    assign pad_cfg = s_q.pad;
    assign alt_in = s_q.alt_in;
    assign avs_readdata = {24'h000000, s_q.rdata};
    assign avs_waitrequest = req & (s_q.bus == GP_BUS_IDLE);
    assign irq = s_q.irq;
    assign adc_trigger = s_q.adc_trig;

    bus_answer_a: assert property (@(posedge clk) disable iff (rst)
        (req && s_q.bus == GP_BUS_IDLE) |-> avs_waitrequest
        ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    data_wmask_a: assert property (@(posedge clk) disable iff (rst)
        (wr_go && data_span) |=> (((s_q.data ^ $past(s_q.data))
        & ~$past(avs_address[9:2]) & $past(s_q.dir)) == 8'h00))
        else $error("masked data write touched an unselected bit");

    data_rmask_a: assert property (@(posedge clk) disable iff (rst)
        (avs_read && data_span && s_q.bus == GP_BUS_IDLE)
        |=> ((avs_readdata[7:0] & ~$past(avs_address[9:2])) == 8'h00))
        else $error("masked data read returned an unselected bit");

    input_capture_a: assert property (@(posedge clk)
        disable iff (rst)
        !(wr_go && data_span) |=> (((s_q.data ^ $past(pad_in))
        & $past(in_sel)) == 8'h00))
        else $error("input pin not captured into data");

    irq_merge_a: assert property (@(posedge clk) disable iff (rst)
        1 |=> (irq == $past(mis_any)))
        else $error("interrupt output not the OR of masked status");

    adc_pulse_a: assert property (@(posedge clk) disable iff (rst)
        adc_trigger |-> (PORT_ID == GP_PORT_B) && s_q.mis_adc
        ##1 !adc_trigger)
        else $error("converter trigger wrong port or longer than a pulse");

    reset_state_a: assert property (@(posedge clk) disable iff (rst)
        $past(rst) |-> (s_q.afsel == gp_afsel_reset(PORT_ID))
        && (s_q.dir == 8'h00) && !irq)
        else $error("pins not at reset defaults after reset");

    drain_high_a: assert property (@(posedge clk) disable iff (rst)
        (s_q.pad.open_drain & pad_oe & out_v) == 8'h00)
        else $error("open drain pin driven high");

    dir_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_go && avs_address == GP_OFF_DIR)
        |=> (s_q.dir == ($past(avs_writedata[7:0]) & PIN_PRESENT)))
        else $error("direction write wrong or reached an absent pin");

    // Catches a write path to dir, mask, sense, both or polarity that forgets the pad mask
    absent_pin_a: assert property (@(posedge clk) disable iff (rst)
        ((s_q.dir | s_q.mask | s_q.sense | s_q.both | s_q.polarity)
        & ~PIN_PRESENT) == 8'h00)
        else $error("absent pin holds a set control bit");

    read_answer_a: assert property (@(posedge clk) disable iff (rst)
        (avs_read && data_span && s_q.bus == GP_BUS_IDLE)
        |=> (avs_readdata[7:0] == ($past(s_q.data)
        & $past(avs_address[9:2]))))
        else $error("masked data read not the stored bits");

    alt_follow_a: assert property (@(posedge clk) disable iff (rst)
        1 |=> (alt_in == $past(pad_in & s_q.pad.dig_en)))
        else $error("peripheral input not the sampled pad");

    // Only port B pin 4 feeds the converter
    adc_port_a: assert property (@(posedge clk) disable iff (rst)
        (PORT_ID != GP_PORT_B) |-> !adc_trigger)
        else $error("converter trigger raised on a port other than B");
endmodule

// File: shared/gp_pkg.sv
// Shared constants, types and helpers for the GPIO port block
package gp_pkg;
    localparam int GP_NPIN = 8;
    localparam int GP_MASK_LSB = 2;
    localparam int GP_ADC_PIN = 4;

    localparam logic [1:0] GP_DATA_SPAN = 2'b00;
    localparam logic [11:0] GP_OFF_DIR = 12'h400;
    localparam logic [11:0] GP_OFF_SENSE = 12'h404;
    localparam logic [11:0] GP_OFF_BOTH = 12'h408;
    localparam logic [11:0] GP_OFF_POL = 12'h40c;
    localparam logic [11:0] GP_OFF_MASK = 12'h410;
    localparam logic [11:0] GP_OFF_RAW = 12'h414;
    localparam logic [11:0] GP_OFF_MIS = 12'h418;
    localparam logic [11:0] GP_OFF_CLR = 12'h41c;
    localparam logic [11:0] GP_OFF_AFSEL = 12'h420;
    localparam logic [11:0] GP_OFF_DRV2 = 12'h500;
    localparam logic [11:0] GP_OFF_DRV4 = 12'h504;
    localparam logic [11:0] GP_OFF_DRV8 = 12'h508;
    localparam logic [11:0] GP_OFF_ODR = 12'h50c;
    localparam logic [11:0] GP_OFF_PUP = 12'h510;
    localparam logic [11:0] GP_OFF_PDN = 12'h514;
    localparam logic [11:0] GP_OFF_SLEW = 12'h518;
    localparam logic [11:0] GP_OFF_DEN = 12'h51c;
    localparam logic [11:0] GP_OFF_PID4 = 12'hfd0;
    localparam logic [11:0] GP_OFF_PID0 = 12'hfe0;
    localparam logic [11:0] GP_OFF_CID0 = 12'hff0;

    localparam logic [7:0] GP_RST_ZERO = 8'h00;
    localparam logic [7:0] GP_RST_DRV2 = 8'hff;
    localparam logic [7:0] GP_RST_PUP = 8'hff;
    localparam logic [7:0] GP_RST_DEN = 8'hff;
    localparam logic [7:0] GP_AFSEL_RST_B = 8'h80;
    localparam logic [7:0] GP_AFSEL_RST_C = 8'h0f;

    // Identification bytes, word 7 down to word 0; values are arbitrary
    localparam logic [63:0] GP_PID_BYTES = 64'h0000_0000_071e_3c5a;
    // Cell identification bytes, word 3 down to word 0; arbitrary
    localparam logic [31:0] GP_CID_BYTES = 32'h4433_2211;

    typedef enum logic [2:0] {
        GP_PORT_A = 3'b000,
        GP_PORT_B = 3'b001,
        GP_PORT_C = 3'b010,
        GP_PORT_D = 3'b011,
        GP_PORT_E = 3'b100
    } gp_port_t;

    typedef enum logic {
        GP_BUS_IDLE = 1'b0,
        GP_BUS_ANS = 1'b1
    } gp_bus_t;

    typedef struct packed {
        logic [7:0] drv2;
        logic [7:0] drv4;
        logic [7:0] drv8;
        logic [7:0] open_drain;
        logic [7:0] pull_up;
        logic [7:0] pull_down;
        logic [7:0] slew;
        logic [7:0] dig_en;
    } gp_pad_t;

    localparam gp_pad_t GP_PAD_RST = '{
        drv2: GP_RST_DRV2, drv4: GP_RST_ZERO, drv8: GP_RST_ZERO,
        open_drain: GP_RST_ZERO, pull_up: GP_RST_PUP,
        pull_down: GP_RST_ZERO, slew: GP_RST_ZERO, dig_en: GP_RST_DEN
    };

    function automatic logic [7:0] gp_afsel_reset(input gp_port_t p);
        gp_afsel_reset = GP_RST_ZERO;
        if (p == GP_PORT_B) begin
            gp_afsel_reset = GP_AFSEL_RST_B;
        end else if (p == GP_PORT_C) begin
            gp_afsel_reset = GP_AFSEL_RST_C;
        end
    endfunction

    function automatic logic [7:0] gp_merge(input logic [7:0] old_v,
            input logic [7:0] new_v, input logic [7:0] m);
        gp_merge = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [7:0] gp_id_byte(input logic [11:0] a);
        logic [2:0] idx;
        idx = {1'b0, a[3:2]};
        gp_id_byte = 8'h00;
        if (a[11:4] == GP_OFF_PID4[11:4]) begin
            gp_id_byte = GP_PID_BYTES[8 * (idx + 3'd4) +: 8];
        end else if (a[11:4] == GP_OFF_PID0[11:4]) begin
            gp_id_byte = GP_PID_BYTES[8 * idx +: 8];
        end else if (a[11:4] == GP_OFF_CID0[11:4]) begin
            gp_id_byte = GP_CID_BYTES[8 * idx +: 8];
        end
    endfunction
endpackage

// File: verif/gp_pin_model.sv
// Pad level model standing on the far side of one port
`timescale 1ns/1ps
module gp_pin_model
    import gp_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire gp_pad_t pad_cfg,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pad_in
);
    logic [7:0] pat_q = 8'h00;
    // Floating pads wander, so a stale value never passes for a real one
    always @(posedge clk) begin
        pat_q <= pat_q + 8'h5b;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i] === 1'b1) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_cfg.pull_up[i]) begin
                pad_in[i] = 1'b1;
            end else if (pad_cfg.pull_down[i]) begin
                pad_in[i] = 1'b0;
            end else begin
                pad_in[i] = pat_q[i];
            end
        end
    end
endmodule

// File: verif/tb_gp_port.sv
// Self-checking bench for one port with pads and peripheral
`timescale 1ns/1ps
module tb_gp_port;
    import gp_pkg::*;
    // Pin 6 left without a pad to exercise ignored bits
    localparam logic [7:0] PRES = 8'hbf;
    localparam logic [4:0] M_SENSE = 5'b11000;
    localparam logic [4:0] M_BOTH = 5'b00100;
    localparam logic [4:0] M_POL = 5'b01001;
    localparam logic [4:0] M_IDLE = 5'b10010;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, adc_trigger;
    logic [7:0] pad_in, pad_out, pad_oe, alt_in;
    logic [7:0] alt_out = 8'h00;
    logic [7:0] alt_oe = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] v, d;
    gp_pad_t pad_cfg;
    logic [31:0] exp_q[$];
    int n_errors = 0;
    int checks_done = 0;
    int n_adc = 0;

    always #10 clk = ~clk;

    gp_port #(.PORT_ID(GP_PORT_B), .PIN_PRESENT(PRES)) i_gp_port (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_cfg(pad_cfg), .alt_out(alt_out), .alt_oe(alt_oe),
        .alt_in(alt_in), .irq(irq), .adc_trigger(adc_trigger));
    gp_pin_model i_gp_pin_model (.clk(clk), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_cfg(pad_cfg), .ext_val(ext_val),
        .ext_en(ext_en), .pad_in(pad_in));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One request; held until the edge where waitrequest is low
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [7:0] dat);
        logic busy;
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, dat};
        avs_write <= w;
        avs_read <= ~w;
        do begin
            @(negedge clk);
            busy = avs_waitrequest;
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 50);
        if (n >= 50) begin
            n_errors++;
            $display("[ERR] %0t bus request not answered", $time);
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] dat);
        bus(1'b1, a, dat);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask

    // Monitor: read data taken at the completing edge only
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk(avs_readdata, exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        if (adc_trigger === 1'b1) begin
            n_adc++;
        end
    end

    initial begin
        #400000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        stop_test();
    end

    initial begin
        void'($urandom(32));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(GP_OFF_DIR, 8'h00);
        rd(GP_OFF_AFSEL, GP_AFSEL_RST_B & PRES);
        rd(GP_OFF_DRV2, 8'hff & PRES);
        rd(GP_OFF_PUP, 8'hff & PRES);
        rd(GP_OFF_DEN, 8'hff & PRES);
        rd(GP_OFF_MASK, 8'h00);
        rd(GP_OFF_PID0 + 12'h004, 8'h3c);
        rd(GP_OFF_CID0 + 12'h004, 8'h22);
        wr(GP_OFF_PID0 + 12'h004, 8'h00);
        rd(GP_OFF_PID0 + 12'h004, 8'h3c);
        rd(12'h600, 8'h00);
        wr(GP_OFF_AFSEL, 8'h00);
        wr(GP_OFF_DIR, 8'hff);
        rd(GP_OFF_DIR, PRES);
        v = 8'($urandom);
        wr(12'h3fc, v);
        @(negedge clk);
        chk({24'h0, pad_out & PRES}, {24'h0, v & PRES});
        chk({24'h0, pad_oe & PRES}, {24'h0, PRES});
        wr(12'h098, 8'heb);
        d = ((v & ~8'h26) | (8'heb & 8'h26)) & PRES;
        rd(12'h3fc, d);
        rd(12'h0c4, d & 8'h31);
        wr(GP_OFF_ODR, 8'h01);
        wr(12'h004, 8'h00);
        @(negedge clk);
        chk({31'h0, pad_oe[0]}, 32'h1);
        wr(12'h004, 8'h01);
        @(negedge clk);
        chk({30'h0, pad_oe[0], pad_out[0]}, 32'h0);
        wr(GP_OFF_ODR, 8'h00);
        wr(GP_OFF_DRV8, 8'h01);
        rd(GP_OFF_DRV2, 8'hfe & PRES);
        wr(GP_OFF_PDN, 8'h02);
        rd(GP_OFF_PUP, 8'hfd & PRES);
        @(negedge clk);
        chk({24'h0, pad_cfg.drv8 & PRES}, 32'h1);
        wr(GP_OFF_AFSEL, 8'hff);
        alt_out <= 8'($urandom);
        alt_oe <= 8'($urandom);
        ext_val <= 8'($urandom);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({24'h0, pad_out & PRES}, {24'h0, alt_out & PRES});
        chk({24'h0, pad_oe & PRES}, {24'h0, alt_oe & PRES});
        chk({24'h0, alt_in & PRES}, {24'h0, PRES & ((alt_out & alt_oe)
            | (ext_val & ~alt_oe))});
        wr(GP_OFF_AFSEL, 8'h00);
        wr(GP_OFF_DIR, 8'h00);
        repeat (3) @(posedge clk);
        rd(12'h3fc, ext_val & PRES);
        for (int m = 0; m < 5; m++) begin
            wr(GP_OFF_MASK, 8'h00);
            wr(GP_OFF_SENSE, {3'h0, M_SENSE[m], 4'h0});
            wr(GP_OFF_BOTH, {3'h0, M_BOTH[m], 4'h0});
            wr(GP_OFF_POL, {3'h0, M_POL[m], 4'h0});
            ext_val[4] <= M_IDLE[m];
            repeat (3) @(posedge clk);
            wr(GP_OFF_CLR, 8'hff);
            rd(GP_OFF_RAW, 8'h00);
            wr(GP_OFF_MASK, 8'h10);
            ext_val[4] <= ~M_IDLE[m];
            repeat (4) @(posedge clk);
            rd(GP_OFF_RAW, 8'h10);
            rd(GP_OFF_MIS, 8'h10);
            @(negedge clk);
            chk({31'h0, irq}, 32'h1);
            @(posedge clk);
            ext_val[4] <= M_IDLE[m];
            repeat (4) @(posedge clk);
            wr(GP_OFF_CLR, 8'hef);
            rd(GP_OFF_RAW, M_SENSE[m] ? 8'h00 : 8'h10);
            wr(GP_OFF_CLR, 8'h10);
            rd(GP_OFF_RAW, 8'h00);
            @(negedge clk);
            chk({31'h0, irq}, 32'h0);
        end
        wr(GP_OFF_MASK, 8'h00);
        ext_val[4] <= 1'b0;
        repeat (4) @(posedge clk);
        rd(GP_OFF_RAW, 8'h10);
        rd(GP_OFF_MIS, 8'h00);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        chk(32'(n_adc), 32'd5);
        chk(32'(exp_q.size()), 32'd0);
        stop_test();
    end
endmodule
